// file: design/mcu_sfr_pkg.sv
// Constants and types shared by the special register file modules
package mcu_sfr_pkg;
  localparam int PC_W = 10;
  localparam int PROG_ADDR_W = 12;
  localparam logic [9:0] PC_RESET_VEC = 10'h3FF;
  localparam logic [9:0] PC_STEP = 10'h001;
  localparam logic [11:0] CFG_WORD_ADDR = 12'h800;
  localparam int CFG_OSC_LSB = 0;
  localparam int CFG_WDT_BIT = 2;
  localparam int CFG_PROTECT_BIT = 3;
  localparam int CFG_MODE_BIT = 6;
  localparam int CFG_PIN_BIT = 7;
  localparam logic [4:0] ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] ADDR_TIMER = 5'h01;
  localparam logic [4:0] ADDR_PCL = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_BANK = 5'h04;
  localparam logic [4:0] ADDR_PORTA = 5'h05;
  localparam logic [4:0] ADDR_PORTB = 5'h06;
  localparam logic [4:0] ADDR_GPR_FIRST = 5'h07;
  localparam logic [4:0] ADDR_GPR_LAST = 5'h1F;
  localparam int GPR_DEPTH = 25;
  localparam logic [7:0] CTRL_RESET = 8'h3F;
  localparam int CTRL_RATIO_LSB = 0;
  localparam int CTRL_ASSIGN_BIT = 3;
  localparam int CTRL_EDGE_BIT = 4;
  localparam int CTRL_SRC_BIT = 5;
  localparam int ST_C_BIT = 0;
  localparam int ST_NIB_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_PWRDN_BIT = 3;
  localparam int ST_TMOUT_BIT = 4;
  localparam int ST_PAGE_BIT = 5;
  localparam logic [3:0] STATUS_LOW_RESET = 4'h0;
  localparam logic STATUS_PAGE_RESET = 1'b0;
  localparam logic [4:0] BANK_RESET = 5'h00;
  localparam logic [2:0] BANK_RD_HIGH = 3'h7;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    OSC_LP,
    OSC_NT,
    OSC_HS,
    OSC_RC
  } osc_type_e;
  typedef enum logic [2:0] {
    PC_INC,
    PC_CALL,
    PC_GOTO,
    PC_LCALL,
    PC_LGOTO,
    PC_RET,
    PC_WRITE
  } pc_op_e;
endpackage : mcu_sfr_pkg

// file: design/pc_ctrl_if.sv
// Control bundle between the register file and its program counter
`timescale 1ns/1ps
interface pc_ctrl_if;
  import mcu_sfr_pkg::*;
  pc_op_e op;
  logic [9:0] operand;
  logic [9:0] stackTop;
  logic [7:0] wrData;
  logic pageSel;
  logic [9:0] pc;
  modport core (output op, operand, stackTop, wrData, pageSel, input pc);
  modport counter (input op, operand, stackTop, wrData, pageSel, output pc);
endinterface : pc_ctrl_if

// file: design/edge_sync.sv
// Two-stage synchroniser with selectable edge detection
`timescale 1ns/1ps
module edge_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pinIn,
  input wire logic fallingSel,
  output logic edgePulse
);
  import mcu_sfr_pkg::*;
  logic [SYNC_STAGES-1:0] syncFf;
  logic prevFf;

  // Pin passes two internal clocks before use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      syncFf <= '0;
      prevFf <= 1'b0;
    end else begin
      syncFf <= {syncFf[SYNC_STAGES-2:0], pinIn};
      prevFf <= syncFf[SYNC_STAGES-1];
    end
  end

  // Edge polarity select
  always_comb begin
    if (fallingSel) begin
      edgePulse = prevFf & ~syncFf[SYNC_STAGES-1];
    end else begin
      edgePulse = ~prevFf & syncFf[SYNC_STAGES-1];
    end
  end
endmodule : edge_sync

// file: design/program_counter.sv
// Ten-bit program counter with page-based short targets
`timescale 1ns/1ps
module program_counter (
  input wire logic mclk,
  input wire logic rst_n,
  pc_ctrl_if.counter pcBus
);
  import mcu_sfr_pkg::*;
  logic [9:0] pcFf;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pcFf <= PC_RESET_VEC;
    end else begin
      case (pcBus.op)
        PC_INC: begin
          pcFf <= pcFf + PC_STEP;
        end
        PC_CALL: begin
          pcFf <= {pcBus.pageSel, 1'b0, pcBus.operand[7:0]};
        end
        PC_GOTO: begin
          pcFf <= {pcBus.pageSel, pcBus.operand[8:0]};
        end
        PC_LCALL, PC_LGOTO: begin
          pcFf <= pcBus.operand;
        end
        PC_RET: begin
          pcFf <= pcBus.stackTop;
        end
        PC_WRITE: begin
          pcFf <= {pcBus.pageSel, 1'b0, pcBus.wrData};
        end
        default: begin
          pcFf <= pcFf;
        end
      endcase
    end
  end

  assign pcBus.pc = pcFf;
endmodule : program_counter

// file: design/mcu_special_register_file.sv
// Special-function registers, data memory and control of the core
//
// Functional notes
// - Ten-bit counter; addresses wrap modulo 1K
// - Start at 3FFH, roll over to 000h
// - Config word at 800H; low bits pick oscillator
// - Config bit 2 enables the watchdog
// - Config bit 3 low turns protection on
// - Config bit 6 selects advanced mode
// - Config bit 7 exposes timer pin
// - Fixed register map plus 25 general bytes
// - Indirect window uses bank pointer address
// - Self-pointing window reads zero, ignores writes
// - Write-only timer control, reset 3FH
// - Prescaler assignment and ratio field
// - Bit 4 picks external clock edge
// - Bit 5 picks external or instruction clock
// - Direction bits: one input, zero output
// - Counter increments, loads targets, pops returns
// - Page bit feeds short targets and writes
// - Long forms use full 10-bit operand
// - Timer read/write, input synchronised twice
// - Software cannot write timeout, power-down flags
// - Carry, nibble carry and zero flags
// - Timeout and power-down flag events
`timescale 1ns/1ps
module mcu_special_register_file (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] cfgWord,
  output logic [11:0] cfgFetchAddr_ff,
  output logic cfgValid_ff,
  input wire logic [4:0] dataAddr,
  input wire logic dataRdEn,
  input wire logic dataWrEn,
  input wire logic [7:0] dataWrData,
  output logic [7:0] dataRdData_ff,
  input wire logic [7:0] accData,
  input wire logic ctrlWrEn,
  input wire logic dirWrEn,
  input wire logic [4:0] dirAddr,
  input wire mcu_sfr_pkg::pc_op_e pcOp,
  input wire logic [11:0] pcTarget,
  input wire logic [9:0] stackTop,
  output logic [9:0] pcValue_ff,
  input wire logic aluArithEn,
  input wire logic aluSubtract,
  input wire logic [7:0] aluOperandA,
  input wire logic [7:0] aluOperandB,
  input wire logic aluLogicEn,
  input wire logic [7:0] aluLogicResult,
  input wire logic wdtClear,
  input wire logic sleepCmd,
  input wire logic wdtOverflow,
  input wire logic timerExtClockPin,
  input wire logic [3:0] portAIn,
  input wire logic [7:0] portBIn,
  output logic [3:0] portAOut_ff,
  output logic [3:0] portAOe_ff,
  output logic [7:0] portBOut_ff,
  output logic [7:0] portBOe_ff,
  output logic [7:0] portBPullup_ff,
  output logic [7:0] portBWakeEn_ff,
  output mcu_sfr_pkg::osc_type_e oscTypeSel_ff,
  output logic watchdogEnable_ff,
  output logic codeProtectOn_ff,
  output logic advancedMode_ff,
  output logic prescalerToWdt_ff,
  output logic [2:0] wdtRatio_ff,
  output logic timerOverflow_ff
);
  import mcu_sfr_pkg::*;

  pc_ctrl_if pcBus ();

  logic [7:0] cfgWordFf;
  logic [7:0] ctrlFf;
  logic [4:0] bankFf;
  logic [7:0] timerFf;
  logic [7:0] presFf;
  logic [3:0] statusLowFf;
  logic pageSelFf;
  logic toFlagNFf;
  logic pwrDownNFf;
  logic [7:0] gprMem [ADDR_GPR_FIRST:ADDR_GPR_LAST];
  logic [4:0] effAddr;
  logic selfRef;
  logic wrEff;
  logic [7:0] rdMux;
  logic extEdge;
  logic srcEvent;
  logic timerTick;
  logic [7:0] ratioMask;
  logic [8:0] arithSum;
  logic [4:0] nibbleSum;
  logic [7:0] operandB;
  logic pinAsPortBit;
  logic [2:0] ratioSel;

  // Configuration word fetch, caught once after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfgFetchAddr_ff <= CFG_WORD_ADDR;
      cfgValid_ff <= 1'b0;
      cfgWordFf <= ZERO_BYTE;
    end else if (!cfgValid_ff) begin
      cfgFetchAddr_ff <= CFG_WORD_ADDR;
      cfgValid_ff <= 1'b1;
      cfgWordFf <= cfgWord;
    end
  end

  // Decoded configuration outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oscTypeSel_ff <= OSC_LP;
      watchdogEnable_ff <= 1'b0;
      codeProtectOn_ff <= 1'b1;
      advancedMode_ff <= 1'b0;
    end else begin
      oscTypeSel_ff <= osc_type_e'(cfgWordFf[CFG_OSC_LSB +: 2]);
      watchdogEnable_ff <= cfgWordFf[CFG_WDT_BIT];
      codeProtectOn_ff <= ~cfgWordFf[CFG_PROTECT_BIT];
      advancedMode_ff <= cfgWordFf[CFG_MODE_BIT];
    end
  end

  assign pinAsPortBit = cfgWordFf[CFG_PIN_BIT] & timerExtClockPin;

  // Indirect redirection through the bank pointer
  always_comb begin
    if (dataAddr == ADDR_INDIRECT) begin
      effAddr = bankFf;
    end else begin
      effAddr = dataAddr;
    end
    selfRef = (effAddr == ADDR_INDIRECT);
    wrEff = dataWrEn & ~selfRef;
  end

  // Read multiplexer over the register map
  always_comb begin
    rdMux = ZERO_BYTE;
    case (effAddr)
      ADDR_INDIRECT: begin
        rdMux = ZERO_BYTE;
      end
      ADDR_TIMER: begin
        rdMux = timerFf;
      end
      ADDR_PCL: begin
        rdMux = pcValue_ff[7:0];
      end
      ADDR_STATUS: begin
        rdMux = {2'b00, pageSelFf, toFlagNFf, pwrDownNFf, statusLowFf[2:0]};
      end
      ADDR_BANK: begin
        rdMux = {BANK_RD_HIGH, bankFf};
      end
      ADDR_PORTA: begin
        rdMux = {3'b000, pinAsPortBit, portAIn};
      end
      ADDR_PORTB: begin
        rdMux = portBIn;
      end
      default: begin
        rdMux = gprMem[effAddr];
      end
    endcase
  end

  // Read data register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dataRdData_ff <= ZERO_BYTE;
    end else if (dataRdEn) begin
      dataRdData_ff <= rdMux;
    end
  end

  // General-purpose bytes, 07h to 1Fh
  always_ff @(posedge mclk) begin
    if (wrEff && (effAddr >= ADDR_GPR_FIRST)) begin
      gprMem[effAddr] <= dataWrData;
    end
  end

  // Bank pointer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bankFf <= BANK_RESET;
    end else if (wrEff && effAddr == ADDR_BANK) begin
      bankFf <= dataWrData[4:0];
    end
  end

  // Write-only timer and watchdog control, loaded from the accumulator
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlFf <= CTRL_RESET;
    end else if (ctrlWrEn) begin
      ctrlFf <= accData;
    end
  end

  assign ratioSel = ctrlFf[CTRL_RATIO_LSB +: 3];

  // Watchdog side of the prescaler setting
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prescalerToWdt_ff <= CTRL_RESET[CTRL_ASSIGN_BIT];
      wdtRatio_ff <= CTRL_RESET[CTRL_RATIO_LSB +: 3];
    end else begin
      prescalerToWdt_ff <= ctrlFf[CTRL_ASSIGN_BIT];
      wdtRatio_ff <= ratioSel;
    end
  end

  edge_sync u_edge_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinIn(timerExtClockPin),
    .fallingSel(ctrlFf[CTRL_EDGE_BIT]),
    .edgePulse(extEdge)
  );

  // Timer clock source and prescaler terminal count
  always_comb begin
    if (ctrlFf[CTRL_SRC_BIT]) begin
      srcEvent = extEdge;
    end else begin
      srcEvent = 1'b1;
    end
    ratioMask = 8'((9'h002 << ratioSel) - 9'h001);
    if (ctrlFf[CTRL_ASSIGN_BIT]) begin
      timerTick = srcEvent;
    end else begin
      timerTick = srcEvent && ((presFf & ratioMask) == ratioMask);
    end
  end

  // Prescaler counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      presFf <= ZERO_BYTE;
    end else if (!ctrlFf[CTRL_ASSIGN_BIT]) begin
      if (wrEff && effAddr == ADDR_TIMER) begin
        presFf <= ZERO_BYTE;
      end else if (srcEvent) begin
        presFf <= presFf + 8'h01;
      end
    end else if (wdtClear || sleepCmd) begin
      presFf <= ZERO_BYTE;
    end
  end

  // Timer register, software write wins over a count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timerFf <= ZERO_BYTE;
      timerOverflow_ff <= 1'b0;
    end else if (wrEff && effAddr == ADDR_TIMER) begin
      timerFf <= dataWrData;
      timerOverflow_ff <= 1'b0;
    end else begin
      if (timerTick) begin
        timerFf <= timerFf + 8'h01;
      end
      timerOverflow_ff <= timerTick && (timerFf == 8'hFF);
    end
  end

  // Arithmetic flags; subtraction adds the two's complement
  always_comb begin
    if (aluSubtract) begin
      operandB = ~aluOperandB;
    end else begin
      operandB = aluOperandB;
    end
    arithSum = {1'b0, aluOperandA} + {1'b0, operandB} + {8'h00, aluSubtract};
    nibbleSum = {1'b0, aluOperandA[3:0]} + {1'b0, operandB[3:0]}
      + {4'h0, aluSubtract};
  end

  // Page bit and ALU flags; an ALU update wins over a register write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      statusLowFf <= STATUS_LOW_RESET;
      pageSelFf <= STATUS_PAGE_RESET;
    end else begin
      if (wrEff && effAddr == ADDR_STATUS) begin
        pageSelFf <= dataWrData[ST_PAGE_BIT];
        statusLowFf[2:0] <= dataWrData[ST_Z_BIT:ST_C_BIT];
      end
      if (aluArithEn) begin
        statusLowFf[ST_C_BIT] <= arithSum[8];
        statusLowFf[ST_NIB_BIT] <= nibbleSum[4];
        statusLowFf[ST_Z_BIT] <= (arithSum[7:0] == ZERO_BYTE);
      end else if (aluLogicEn) begin
        statusLowFf[ST_Z_BIT] <= (aluLogicResult == ZERO_BYTE);
      end
    end
  end

  // Timeout flag, hardware only; overflow wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      toFlagNFf <= 1'b1;
    end else if (wdtOverflow) begin
      toFlagNFf <= 1'b0;
    end else if (wdtClear || sleepCmd) begin
      toFlagNFf <= 1'b1;
    end
  end

  // Power-down flag, hardware only; sleep wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwrDownNFf <= 1'b1;
    end else if (sleepCmd) begin
      pwrDownNFf <= 1'b0;
    end else if (wdtClear) begin
      pwrDownNFf <= 1'b1;
    end
  end

  // Port output latches
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      portAOut_ff <= 4'h0;
      portBOut_ff <= ZERO_BYTE;
    end else if (wrEff && effAddr == ADDR_PORTA) begin
      portAOut_ff <= dataWrData[3:0];
    end else if (wrEff && effAddr == ADDR_PORTB) begin
      portBOut_ff <= dataWrData;
    end
  end

  // Write-only direction; enables hold the inverse of direction bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      portAOe_ff <= 4'h0;
      portBOe_ff <= ZERO_BYTE;
    end else if (dirWrEn && dirAddr == ADDR_PORTA) begin
      portAOe_ff <= ~accData[3:0];
    end else if (dirWrEn && dirAddr == ADDR_PORTB) begin
      portBOe_ff <= ~accData;
    end
  end

  // Advanced mode pull-ups and pin-change wake on input pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      portBPullup_ff <= ZERO_BYTE;
      portBWakeEn_ff <= ZERO_BYTE;
    end else begin
      portBPullup_ff <= {8{advancedMode_ff}} & ~portBOe_ff;
      portBWakeEn_ff <= {8{advancedMode_ff}} & ~portBOe_ff;
    end
  end

  // Program counter control
  always_comb begin
    if (wrEff && effAddr == ADDR_PCL) begin
      pcBus.op = PC_WRITE;
    end else begin
      pcBus.op = pcOp;
    end
    pcBus.operand = pcTarget[PC_W-1:0];
    pcBus.stackTop = stackTop;
    pcBus.wrData = dataWrData;
    pcBus.pageSel = pageSelFf;
  end

  program_counter u_program_counter (
    .mclk(mclk),
    .rst_n(rst_n),
    .pcBus(pcBus.counter)
  );

  assign pcValue_ff = pcBus.pc;
endmodule : mcu_special_register_file

// file: testbench/mcu_sfr_monitor.sv
// Assertion checker bound to the special register file
`timescale 1ns/1ps
module mcu_sfr_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] cfgWord,
  input wire logic cfgValid_ff,
  input wire logic [4:0] dataAddr,
  input wire logic dataRdEn,
  input wire logic dataWrEn,
  input wire logic [7:0] dataWrData,
  input wire logic [7:0] dataRdData_ff,
  input wire logic [7:0] accData,
  input wire logic ctrlWrEn,
  input wire mcu_sfr_pkg::pc_op_e pcOp,
  input wire logic [11:0] pcTarget,
  input wire logic [9:0] stackTop,
  input wire logic [9:0] pcValue_ff,
  input wire logic watchdogEnable_ff,
  input wire logic codeProtectOn_ff,
  input wire logic advancedMode_ff,
  input wire logic prescalerToWdt_ff,
  input wire logic [2:0] wdtRatio_ff,
  input wire logic timerOverflow_ff
);
  import mcu_sfr_pkg::*;
  logic pclWr;
  logic longOp;
  logic [9:0] tgtLow;
  logic [3:0] accLow;
  logic [2:0] cfgBits;
  assign tgtLow = pcTarget[9:0];
  assign accLow = accData[3:0];
  assign cfgBits = {cfgWord[CFG_MODE_BIT], cfgWord[CFG_PROTECT_BIT],
    cfgWord[CFG_WDT_BIT]};
  assign pclWr = dataWrEn && dataAddr == ADDR_PCL;
  assign longOp = (pcOp == PC_LGOTO || pcOp == PC_LCALL) && !pclWr;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence ctrlLoad;
    ctrlWrEn ##1 1'b1;
  endsequence
  sequence cfgCaught;
    $rose(cfgValid_ff);
  endsequence
  a_pc_step: assert property (pcOp == PC_INC && !pclWr |=>
    pcValue_ff == $past(pcValue_ff) + PC_STEP)
    else $error("pc step wrong");
  a_long_branch: assert property (longOp |=>
    pcValue_ff == $past(tgtLow))
    else $error("long branch target wrong");
  a_ret_pop: assert property (pcOp == PC_RET && !pclWr |=>
    pcValue_ff == $past(stackTop))
    else $error("return value wrong");
  a_pcl_write: assert property (pclWr |=>
    pcValue_ff[8:0] == {1'b0, $past(dataWrData)})
    else $error("counter write wrong");
  a_ctrl_load: assert property (ctrlLoad |=>
    {prescalerToWdt_ff, wdtRatio_ff} == $past(accLow, 2))
    else $error("control decode wrong");
  a_cfg_decode: assert property (cfgCaught |=>
    {advancedMode_ff, ~codeProtectOn_ff, watchdogEnable_ff} ==
    $past(cfgBits, 2))
    else $error("config decode wrong");
  a_ovf_pulse: assert property (timerOverflow_ff |=>
    !timerOverflow_ff)
    else $error("overflow pulse too long");
  a_bank_read: assert property (dataRdEn &&
    dataAddr == ADDR_BANK |=> dataRdData_ff[7:5] == BANK_RD_HIGH)
    else $error("bank read high bits wrong");
endmodule : mcu_sfr_monitor
bind mcu_special_register_file mcu_sfr_monitor u_mcu_sfr_monitor (
  .mclk, .rst_n, .cfgWord, .cfgValid_ff, .dataAddr, .dataRdEn,
  .dataWrEn, .dataWrData, .dataRdData_ff, .accData, .ctrlWrEn, .pcOp,
  .pcTarget, .stackTop, .pcValue_ff, .watchdogEnable_ff,
  .codeProtectOn_ff, .advancedMode_ff, .prescalerToWdt_ff,
  .wdtRatio_ff, .timerOverflow_ff
);

// file: testbench/mcu_special_register_file_tb.sv
// Self-checking bench for the special register file
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nFail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module mcu_special_register_file_tb;
  import mcu_sfr_pkg::*;
  logic mclk, rst_n, dataRdEn, dataWrEn, ctrlWrEn, dirWrEn;
  logic aluArithEn, aluSubtract, aluLogicEn, wdtClear, sleepCmd;
  logic wdtOverflow, timerExtClockPin, cfgValid_ff, watchdogEnable_ff;
  logic codeProtectOn_ff, advancedMode_ff, prescalerToWdt_ff;
  logic timerOverflow_ff;
  logic [7:0] cfgWord, dataWrData, dataRdData_ff, accData, aluOperandA;
  logic [7:0] aluOperandB, aluLogicResult, portBIn, portBOut_ff;
  logic [7:0] portBOe_ff, portBPullup_ff, portBWakeEn_ff, q, t0, t1;
  logic [4:0] dataAddr, dirAddr;
  logic [11:0] pcTarget, cfgFetchAddr_ff;
  logic [9:0] stackTop, pcValue_ff;
  logic [3:0] portAIn, portAOut_ff, portAOe_ff;
  logic [2:0] wdtRatio_ff;
  pc_op_e pcOp;
  osc_type_e oscTypeSel_ff;
  int nFail, nTests, k;
  logic [7:0] cv[3] = '{8'h08, 8'h00, 8'h02};
  int wv[3] = '{6, 6, 30};
  mcu_special_register_file u_mcu_special_register_file (.*);
  always #2.5 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic io(input logic w, input logic [4:0] a,
      input logic [7:0] d, output logic [7:0] r);
    dataAddr = a;
    dataWrData = d;
    dataWrEn = w;
    dataRdEn = !w;
    tick(1);
    dataWrEn = 1'b0;
    dataRdEn = 1'b0;
    tick(1);
    r = dataRdData_ff;
  endtask : io
  task automatic chkRd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] r;
    io(1'b0, a, 8'h00, r);
    `CHK(r, e)
  endtask : chkRd
  task automatic load(input logic d, input logic [4:0] a,
      input logic [7:0] v);
    accData = v;
    dirAddr = a;
    ctrlWrEn = !d;
    dirWrEn = d;
    tick(1);
    ctrlWrEn = 1'b0;
    dirWrEn = 1'b0;
    tick(3);
  endtask : load
  task automatic pcStep(input pc_op_e op, input logic [11:0] t,
      input logic [9:0] e);
    pcOp = op;
    pcTarget = t;
    tick(1);
    `CHK(pcValue_ff, e)
    pcOp = PC_INC;
    tick(1);
  endtask : pcStep
  task automatic alu(input logic s, input logic [7:0] a, b);
    logic [8:0] r;
    logic [4:0] n;
    r = {1'b0, a} + (s ? {1'b0, ~b} + 9'h001 : {1'b0, b});
    n = {1'b0, a[3:0]} + (s ? {1'b0, ~b[3:0]} + 5'h01 : {1'b0, b[3:0]});
    aluSubtract = s;
    aluOperandA = a;
    aluOperandB = b;
    aluArithEn = 1'b1;
    tick(1);
    aluArithEn = 1'b0;
    chkRd(ADDR_STATUS, {5'h03, r[7:0] == 8'h00, n[4], r[8]});
  endtask : alu
  task automatic doReset(input logic [7:0] c);
    rst_n = 1'b0;
    cfgWord = c;
    tick(10);
    `CHK(pcValue_ff, PC_RESET_VEC)
    rst_n = 1'b1;
    tick(1);
    `CHK(pcValue_ff, 10'h000)
    tick(2);
  endtask : doReset
  task automatic reportAndStop;
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : reportAndStop
  initial begin
    {mclk, dataRdEn, dataWrEn, ctrlWrEn, dirWrEn, aluArithEn} = '0;
    {aluSubtract, aluLogicEn, wdtClear, sleepCmd, wdtOverflow} = '0;
    {dataWrData, accData, aluOperandA, aluOperandB} = '0;
    {dataAddr, dirAddr, pcTarget, aluLogicResult} = '0;
    {nFail, nTests} = '0;
    stackTop = 10'h155;
    timerExtClockPin = 1'b1;
    portAIn = 4'h5;
    portBIn = 8'hA6;
    pcOp = PC_INC;
    for (int i = 0; i < 4; i++) begin
      doReset({i[1:0], 2'b00, i[1:0], i[1:0]});
      `CHK(oscTypeSel_ff, osc_type_e'(i[1:0]))
      `CHK(watchdogEnable_ff, i[0])
      `CHK(codeProtectOn_ff, !i[1])
      `CHK(advancedMode_ff, i[0])
      chkRd(ADDR_PORTA, {3'b000, i[1], 4'h5});
    end
    `CHK({prescalerToWdt_ff, wdtRatio_ff}, 4'hF)
    `CHK(cfgFetchAddr_ff, 12'h800)
    `CHK({portAOe_ff, portBOe_ff}, 12'h000)
    chkRd(ADDR_STATUS, 8'h18);
    io(1'b1, ADDR_STATUS, 8'h00, q);
    chkRd(ADDR_STATUS, 8'h18);
    wdtOverflow = 1'b1;
    tick(1);
    wdtOverflow = 1'b0;
    chkRd(ADDR_STATUS, 8'h08);
    io(1'b1, ADDR_STATUS, 8'h10, q);
    chkRd(ADDR_STATUS, 8'h08);
    sleepCmd = 1'b1;
    tick(1);
    sleepCmd = 1'b0;
    chkRd(ADDR_STATUS, 8'h10);
    wdtClear = 1'b1;
    tick(1);
    wdtClear = 1'b0;
    chkRd(ADDR_STATUS, 8'h18);
    for (int a = 7; a < 32; a++) io(1'b1, a[4:0], {3'h5, a[4:0]}, q);
    for (int a = 7; a < 32; a++) chkRd(a[4:0], {3'h5, a[4:0]});
    io(1'b1, ADDR_BANK, 8'h10, q);
    io(1'b1, ADDR_INDIRECT, 8'hA5, q);
    chkRd(5'h10, 8'hA5);
    chkRd(ADDR_INDIRECT, 8'hA5);
    io(1'b1, ADDR_BANK, 8'h00, q);
    io(1'b1, ADDR_INDIRECT, 8'h5A, q);
    chkRd(ADDR_INDIRECT, 8'h00);
    chkRd(ADDR_BANK, 8'hE0);
    io(1'b1, ADDR_STATUS, 8'h20, q);
    pcStep(PC_CALL, 12'h0AB, 10'h2AB);
    pcStep(PC_GOTO, 12'h1CD, 10'h3CD);
    pcStep(PC_LGOTO, 12'hC12, 10'h012);
    pcStep(PC_RET, 12'h000, 10'h155);
    io(1'b1, ADDR_PCL, 8'h34, q);
    `CHK(pcValue_ff, 10'h235)
    pcStep(PC_WRITE, 12'h000, 10'h234);
    io(1'b1, ADDR_STATUS, 8'h00, q);
    pcStep(PC_LCALL, 12'h1FF, 10'h1FF);
    `CHK(pcValue_ff, 10'h200)
    chkRd(ADDR_STATUS, 8'h18);
    alu(1'b0, 8'h0F, 8'h01);
    alu(1'b0, 8'h80, 8'h80);
    alu(1'b1, 8'hB0, 8'h50);
    alu(1'b1, 8'h50, 8'hB0);
    aluLogicEn = 1'b1;
    tick(1);
    aluLogicEn = 1'b0;
    chkRd(ADDR_STATUS, 8'h1E);
    for (int j = 0; j < 3; j++) begin
      load(1'b0, 5'h00, cv[j]);
      `CHK({prescalerToWdt_ff, wdtRatio_ff}, cv[j][3:0])
      io(1'b0, ADDR_TIMER, 8'h00, t0);
      tick(wv[j]);
      io(1'b0, ADDR_TIMER, 8'h00, t1);
      k = cv[j][3] ? 0 : cv[j][2:0] + 1;
      `CHK(8'(t1 - t0), 8'((wv[j] + 2) >> k))
    end
    timerExtClockPin = 1'b0;
    load(1'b0, 5'h00, 8'h28);
    io(1'b0, ADDR_TIMER, 8'h00, t0);
    timerExtClockPin = 1'b1;
    tick(6);
    io(1'b0, ADDR_TIMER, 8'h00, t1);
    `CHK(8'(t1 - t0), 8'h01)
    load(1'b0, 5'h00, 8'h38);
    io(1'b0, ADDR_TIMER, 8'h00, t0);
    timerExtClockPin = 1'b0;
    tick(6);
    io(1'b0, ADDR_TIMER, 8'h00, t1);
    `CHK(8'(t1 - t0), 8'h01)
    load(1'b0, 5'h00, 8'h08);
    io(1'b1, ADDR_TIMER, 8'hFE, q);
    k = 0;
    while (timerOverflow_ff !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    `CHK(k < 20, 1'b1)
    load(1'b1, ADDR_PORTB, 8'h0F);
    `CHK(portBOe_ff, 8'hF0)
    `CHK(portBPullup_ff, 8'h0F)
    `CHK(portBWakeEn_ff, 8'h0F)
    load(1'b1, ADDR_PORTA, 8'h0A);
    load(1'b1, 5'h07, 8'h00);
    `CHK({portAOe_ff, portBOe_ff}, 12'h5F0)
    io(1'b1, ADDR_PORTB, 8'h3C, q);
    `CHK(portBOut_ff, 8'h3C)
    chkRd(ADDR_PORTB, 8'hA6);
    io(1'b1, ADDR_PORTA, 8'hF9, q);
    `CHK(portAOut_ff, 4'h9)
    reportAndStop();
  end
endmodule : mcu_special_register_file_tb
